// *** rtl/adcpt_pkg.sv ***
// Constants and types for the PWM, timer and converter trigger routing
// Overview of operation
// - When selected, the PWM reload strobe feeds the channel 3 input of timer_module_a.
// - Timer channel 3 output drives the primary_conversion_trigger.
// - Timer channel 2 output drives the secondary_conversion_trigger.
// - The primary trigger starts both converters in sequential or simultaneous mode.
// - The secondary trigger starts only converter_b, and only in independent mode.
// - Control bits of the system_integration_module control word enable the connections.
// - Limit flags, timer outputs and GPIO can drive the PWM outputs like the generator.
// - Active-low signals are asserted when low; active-high ones when high.
package adcpt_pkg;

  // ****************************************
  // Control word layout
  // ****************************************
  localparam int SYSINT_CTRL_W = 8;
  localparam int SYSINT_RELOAD_ROUTE_BIT = 0;
  localparam int SYSINT_TRIG_ROUTE_BIT = 1;
  localparam logic [SYSINT_CTRL_W-1:0] SYSINT_CTRL_RESET = 8'h00;

  // ****************************************
  // PWM pairs and synchroniser
  // ****************************************
  localparam int PWM_PAIRS = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic PWM_OUT_RESET = 1'b0;

  // Converter sequencing modes
  typedef enum logic [1:0] {
    ADCPT_SEQUENTIAL,
    ADCPT_SIMUL_PARALLEL,
    ADCPT_INDEP_PARALLEL
  } adcpt_mode_t;

  // Source of one complementary PWM pair
  typedef enum logic [1:0] {
    ADCPT_SRC_GENERATOR,
    ADCPT_SRC_ADC_LIMIT,
    ADCPT_SRC_TIMER,
    ADCPT_SRC_GPIO
  } adcpt_src_t;

  // Master trigger owns both converters in these modes
  function automatic logic adcpt_master_mode(adcpt_mode_t mode);
    return (mode == ADCPT_SEQUENTIAL) || (mode == ADCPT_SIMUL_PARALLEL);
  endfunction

endpackage

// *** rtl/adcpt_pwm_src.sv ***
// Source selector for one complementary PWM output pair
`timescale 1ns/100ps
module adcpt_pwm_src
  import adcpt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Selection
  input wire adcpt_src_t src_sel,
  // Candidate sources
  input wire logic gen_top,
  input wire logic gen_bot,
  input wire logic over_limit,
  input wire logic under_limit,
  input wire logic timer_in,
  input wire logic gpio_in,
  // Pair outputs
  output logic pwm_top_ff,
  output logic pwm_bot_ff
);

  logic nxt_top;
  logic nxt_bot;

  // Pick the pair drive; only the generator source can drive both high
  // alternate sources
  always_comb begin
    nxt_top = gen_top;
    nxt_bot = gen_bot;
    case (src_sel)
      ADCPT_SRC_GENERATOR: begin
        nxt_top = gen_top;
        nxt_bot = gen_bot;
      end
      ADCPT_SRC_ADC_LIMIT: begin
        // Below limit pulls up, above limit pulls down
        nxt_top = under_limit & ~over_limit;
        nxt_bot = over_limit;
      end
      ADCPT_SRC_TIMER: begin
        nxt_top = timer_in;
        nxt_bot = ~timer_in;
      end
      default: begin
        nxt_top = gpio_in;
        nxt_bot = ~gpio_in;
      end
    endcase
  end

  // Registered so the pad sees no select glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_top_ff <= PWM_OUT_RESET;
      pwm_bot_ff <= PWM_OUT_RESET;
    end else begin
      pwm_top_ff <= nxt_top;
      pwm_bot_ff <= nxt_bot;
    end
  end

endmodule

// *** rtl/adcpt_router.sv ***
// Trigger and PWM source routing between PWM, timer_module_a and converters
`timescale 1ns/100ps
module adcpt_router
  import adcpt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control word of the system_integration_module
  input wire logic [SYSINT_CTRL_W-1:0] sysint_ctrl,
  input wire adcpt_mode_t conv_mode,
  // PWM reload strobe and timer pin
  input wire logic pwm_reload_sync,
  input wire logic timer_a_ch3_pin,
  // Timer module A channel outputs
  input wire logic timer_a_ch2_out,
  input wire logic timer_a_ch3_out,
  // Timer module A channel 3 input
  output logic timer_a_ch3_in,
  // Conversion triggers
  output logic primary_conversion_trigger,
  output logic secondary_conversion_trigger,
  output logic converter_a_start,
  output logic converter_b_start,
  // PWM pair sources
  input wire adcpt_src_t [PWM_PAIRS-1:0] pwm_src_sel,
  input wire logic [PWM_PAIRS-1:0] gen_top,
  input wire logic [PWM_PAIRS-1:0] gen_bot,
  input wire logic adc_over_limit,
  input wire logic adc_under_limit,
  input wire logic [PWM_PAIRS-1:0] timer_pwm,
  input wire logic [PWM_PAIRS-1:0] gpio_pwm_n,
  // PWM pair outputs
  output logic [PWM_PAIRS-1:0] pwm_top,
  output logic [PWM_PAIRS-1:0] pwm_bot
);

  // ****************************************
  // Pin synchronisers
  // ****************************************

  logic [1:0] ch3_pin_sync_ff;
  logic [1:0] gpio_s1_ff [PWM_PAIRS];
  logic [PWM_PAIRS-1:0] gpio_sync_ff;
  logic reload_route;
  logic trig_route;

  // Timer pin arrives asynchronously: two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ch3_pin_sync_ff <= SYNC_RESET;
    end else begin
      ch3_pin_sync_ff <= {ch3_pin_sync_ff[0], timer_a_ch3_pin};
    end
  end

  // GPIO pins: three flops each, first stage read only by the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_s1_ff[0] <= SYNC_RESET;
      gpio_s1_ff[1] <= SYNC_RESET;
      gpio_s1_ff[2] <= SYNC_RESET;
      gpio_sync_ff <= '1;
    end else begin
      gpio_s1_ff[0] <= {gpio_s1_ff[0][0], gpio_pwm_n[0]};
      gpio_s1_ff[1] <= {gpio_s1_ff[1][0], gpio_pwm_n[1]};
      gpio_s1_ff[2] <= {gpio_s1_ff[2][0], gpio_pwm_n[2]};
      gpio_sync_ff <= {gpio_s1_ff[2][1], gpio_s1_ff[1][1], gpio_s1_ff[0][1]};
    end
  end

  // ****************************************
  // Trigger routing
  // ****************************************

  assign reload_route = sysint_ctrl[SYSINT_RELOAD_ROUTE_BIT];
  assign trig_route = sysint_ctrl[SYSINT_TRIG_ROUTE_BIT];

  // Pure gating keeps each timer edge a single trigger; a flop here
  // would delay conversions behind the PWM reload by one cycle
  // reload strobe into channel 3
  assign timer_a_ch3_in = reload_route ? pwm_reload_sync : ch3_pin_sync_ff[1];

  // channel 3 to primary trigger, no latency
  assign primary_conversion_trigger = trig_route & timer_a_ch3_out;

  // channel 2 to secondary trigger, no latency
  assign secondary_conversion_trigger = trig_route & timer_a_ch2_out;

  // master trigger always starts converter A
  assign converter_a_start = primary_conversion_trigger;

  // converter B follows secondary only in independent mode
  assign converter_b_start = adcpt_master_mode(conv_mode) ? primary_conversion_trigger
                           : (conv_mode == ADCPT_INDEP_PARALLEL) & secondary_conversion_trigger;

  // ****************************************
  // PWM source selection
  // ****************************************

  // One selector per complementary pair
  for (genvar p = 0; p < PWM_PAIRS; p++) begin : g_pair
    adcpt_pwm_src u_src (
      .mclk(mclk),
      .rst_n(rst_n),
      .src_sel(pwm_src_sel[p]),
      .gen_top(gen_top[p]),
      .gen_bot(gen_bot[p]),
      .over_limit(adc_over_limit),
      .under_limit(adc_under_limit),
      .timer_in(timer_pwm[p]),
      .gpio_in(~gpio_sync_ff[p]),
      .pwm_top_ff(pwm_top[p]),
      .pwm_bot_ff(pwm_bot[p])
    );
  end

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  reload_route_a: assert property (
    reload_route |-> (timer_a_ch3_in == pwm_reload_sync))
    else $error("channel 3 input does not follow reload strobe");

  pin_route_a: assert property (
    (!reload_route && $stable(timer_a_ch3_pin))[*3] |-> (timer_a_ch3_in == timer_a_ch3_pin))
    else $error("channel 3 input does not follow synchronised pin");

  primary_src_a: assert property (
    primary_conversion_trigger == (trig_route && timer_a_ch3_out))
    else $error("primary trigger not driven by channel 3");

  secondary_src_a: assert property (
    secondary_conversion_trigger == (trig_route && timer_a_ch2_out))
    else $error("secondary trigger not driven by channel 2");

  master_both_a: assert property (
    adcpt_master_mode(conv_mode) && primary_conversion_trigger
      |-> converter_a_start && converter_b_start)
    else $error("master trigger did not start both converters");

  indep_only_a: assert property (
    conv_mode == ADCPT_INDEP_PARALLEL
      |-> (converter_b_start == secondary_conversion_trigger))
    else $error("converter B not on secondary trigger in independent mode");

  sec_not_a_a: assert property (
    secondary_conversion_trigger && !primary_conversion_trigger |-> !converter_a_start)
    else $error("secondary trigger started converter A");

  route_gate_a: assert property (
    !trig_route |-> !converter_a_start && !converter_b_start)
    else $error("trigger passed while routing disabled");

  // timer source drives pair 0 next cycle
  timer_drive_a: assert property (
    pwm_src_sel[0] == ADCPT_SRC_TIMER |=> pwm_top[0] == $past(timer_pwm[0])
      && pwm_bot[0] != pwm_top[0])
    else $error("timer source not driving PWM pair 0");

  // low GPIO pin asserts top output four cycles on
  gpio_low_a: assert property (
    (pwm_src_sel[1] == ADCPT_SRC_GPIO)[*4] ##0 ($past(gpio_pwm_n[1], 4) == 1'b0)
      |-> pwm_top[1])
    else $error("active-low GPIO not treated as asserted");

  // pulse width kept on converter A
  width_keep_a: assert property (
    $rose(timer_a_ch3_out) && trig_route ##1 $fell(timer_a_ch3_out) && trig_route
      |-> $fell(converter_a_start))
    else $error("trigger pulse width altered");

  // Main scenarios
  cov_master_c: cover property (
    adcpt_master_mode(conv_mode) && $rose(converter_b_start));
  cov_indep_c: cover property (
    conv_mode == ADCPT_INDEP_PARALLEL && secondary_conversion_trigger);
  cov_reload_c: cover property (reload_route && $rose(timer_a_ch3_in));
  cov_limit_c: cover property (
    pwm_src_sel[2] == ADCPT_SRC_ADC_LIMIT && pwm_bot[2]);

endmodule

// *** verification/adcpt_timer_model.sv ***
// Behavioural timer_module_a channel outputs facing the router
`timescale 1ns/100ps
module adcpt_timer_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pulse requests
  input wire logic fire2,
  input wire logic fire3,
  // Channel outputs
  output logic timer_a_ch2_out,
  output logic timer_a_ch3_out
);
  // active-high pulses
  // Registered like a compare output, so pulses land one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_ch2_out <= 1'b0;
      timer_a_ch3_out <= 1'b0;
    end else begin
      timer_a_ch2_out <= fire2;
      timer_a_ch3_out <= fire3;
    end
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the trigger and PWM source router
`timescale 1ns/100ps
module tb;
  import adcpt_pkg::*;
  // ****************************************
  // Stimulus word and history
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] stim_w = 32'h0;
  logic [31:0] h [0:4] = '{default: 32'h0};
  logic [31:0] seed = 32'h6E0C;
  logic [31:0] corner [0:3] = '{32'hFFFFFFFF, 32'h0C000003, 32'h0C00000B, 32'h0C00000F};
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic ch2, ch3, ch3_in, prim, sec, a_st, b_st;
  logic [PWM_PAIRS-1:0] p_top, p_bot;
  adcpt_src_t [PWM_PAIRS-1:0] sel;
  for (genvar i = 0; i < PWM_PAIRS; i++) begin : g_sel
    assign sel[i] = adcpt_src_t'(stim_w[4+2*i +: 2]);
  end
  adcpt_timer_model adcpt_timer_model_i (.mclk(mclk), .rst_n(rst_n),
    .fire2(stim_w[26]), .fire3(stim_w[27]), .timer_a_ch2_out(ch2), .timer_a_ch3_out(ch3));
  adcpt_router adcpt_router_i (.mclk(mclk), .rst_n(rst_n), .sysint_ctrl({6'h00, stim_w[1:0]}),
    .conv_mode(adcpt_mode_t'(stim_w[3:2])), .pwm_reload_sync(stim_w[24]),
    .timer_a_ch3_pin(stim_w[25]), .timer_a_ch2_out(ch2), .timer_a_ch3_out(ch3),
    .timer_a_ch3_in(ch3_in),
    .primary_conversion_trigger(prim), .secondary_conversion_trigger(sec),
    .converter_a_start(a_st), .converter_b_start(b_st), .pwm_src_sel(sel),
    .gen_top(stim_w[12:10]), .gen_bot(stim_w[15:13]), .adc_over_limit(stim_w[16]),
    .adc_under_limit(stim_w[17]), .timer_pwm(stim_w[20:18]), .gpio_pwm_n(stim_w[23:21]),
    .pwm_top(p_top), .pwm_bot(p_bot));
  // Free-running 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pair drive for a select word; GPIO level comes from an older word
  function automatic logic [1:0] exp_pair(input logic [31:0] w, input logic g_n, input int i);
    case (w[4+2*i +: 2])
      2'h0: return {w[10+i], w[13+i]};
      2'h1: return {w[17] & ~w[16], w[16]};
      2'h2: return {w[18+i], ~w[18+i]};
      default: return {~g_n, g_n};
    endcase
  endfunction
  function automatic logic exp_b(input logic [1:0] m, input logic p, input logic s);
    return (m < 2'h2) ? p : ((m == 2'h2) ? s : 1'b0);
  endfunction
  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pwm(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge mclk);
    rst_n <= 1'b1;
    cyc = 0;
  endtask
  // One cycle: drive a word, then judge settled outputs mid-cycle
  task automatic step(input logic [31:0] w);
    logic p;
    logic s;
    @(posedge mclk);
    stim_w <= w;
    for (int k = 4; k > 0; k--) h[k] = h[k-1];
    h[0] = w;
    cyc++;
    @(negedge mclk);
    if (cyc > 6) begin
      p = h[0][1] & h[1][27];
      s = h[0][1] & h[1][26];
      cmp_bit(prim, p);
      cmp_bit(sec, s);
      cmp_bit(a_st, p);
      cmp_bit(b_st, exp_b(h[0][3:2], p, s));
      cmp_bit(ch3_in, h[0][0] ? h[0][24] : h[2][25]);
      for (int i = 0; i < PWM_PAIRS; i++) begin
        cmp_pwm({p_top[i], p_bot[i]}, exp_pair(h[1], h[4][21+i], i));
      end
    end
  endtask
  // Watchdog sized well past the roughly 430 cycles of tests
  initial begin
    #(100 * 3000);
    num_errors++;
    give_verdict();
  end
  initial begin
    do_reset(6);
    for (int r = 0; r < 12; r++) step(corner[r % 4]);
    for (int r = 0; r < 8; r++) step(r[0] ? 32'hFFFFFFFF : 32'h0);
    $display("corner test done");
    do_reset(3);
    for (int r = 0; r < 400; r++) begin
      seed = lfsr(seed);
      step(seed);
    end
    $display("random test done");
    give_verdict();
  end
endmodule
